// file: rtl/pibc_top.sv
/*
  power mode control, interrupt enable and breakpoint controller.
  assumes a single-cycle cpu register port on i_clock, program counter
  from the same domain, and wake/boost sense lines from the pads.
*/
// Function
// - boost status bit 2 is read-only, one when rails below 3.0V
// - writing one to sleep bit stops clock and powers down analog blocks
// - while asleep counters freeze and pulse-width outputs hold their level
// - sleep ends on enabled wake activity, cpu resumes within 0.5 ms
// - other writable power bits are wake enables honoured only in sleep
// - writing one to halt bit stops only the cpu
// - halt ends on any enabled interrupt; two instructions may still run
// - enable bit 12 gates the bus-role change interrupt
// - enable bit 11 gates all three synchronous serial interrupts
// - enable bits 9 and 8 gate serial engine 2 and 1 interrupts
// - enable bit 7 gates fast serial port interrupts
// - enable bits 6 and 5 gate inbound and outbound mailbox interrupts
// - enable bit 3 gates both asynchronous serial port interrupts
// - enable bit 2 gates gpio interrupt; clearing discards pending gpio
// - enable bit 1 gates second timer; clearing discards its pending
// - enable bit 0 gates first timer; clearing discards its pending
// - breakpoint interrupt rises when program counter equals breakpoint
// - writing zero to breakpoint register drops the breakpoint interrupt
`timescale 1ns/1ps
module pibc_top #(
  parameter int P_RESUME_CYCLES = pibc_pkg::RESUME_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic [15:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [15:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  input wire logic i_boost_low,
  input wire logic [15:0] i_wake_line,
  input wire logic [15:0] i_irq_event,
  input wire logic [15:0] i_irq_ack,
  input wire logic [15:0] i_pc,
  input wire logic i_pc_valid,
  output logic [15:0] o_irq_req,
  output logic o_breakpoint_irq,
  output logic o_cpu_stop,
  output logic o_clock_stop,
  output logic o_analog_power_down
);

  pibc_gate_if gif ();

  pibc_pkg::pibc_mode_e state_r;
  pibc_pkg::pibc_mode_e state_nxt;
  logic [15:0] wake_en_r;
  logic [15:0] ien_r;
  logic [15:0] bp_addr_r;
  logic bp_irq_r;
  logic [15:0] rdata_r;
  logic cpu_stop_r;
  logic clock_stop_r;
  logic power_down_r;
  logic [16:0] resume_cnt_r;
  logic [15:0] wake_s1_r;
  logic [15:0] wake_s2_r;
  logic [15:0] wake_s3_r;
  logic boost_s1_r;
  logic boost_s2_r;
  logic wr_pwr;
  logic wr_ien;
  logic wr_bp;
  logic [15:0] wake_hit;
  logic bp_match;
  logic resume_done;

  // ----------------------------------------------------------------
  // pad synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      wake_s1_r <= pibc_pkg::ZERO16;
      wake_s2_r <= pibc_pkg::ZERO16;
      wake_s3_r <= pibc_pkg::ZERO16;
    end else begin
      wake_s1_r <= i_wake_line;
      wake_s2_r <= wake_s1_r;
      wake_s3_r <= wake_s2_r;
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      boost_s1_r <= 1'b0;
      boost_s2_r <= 1'b0;
    end else begin
      boost_s1_r <= i_boost_low;
      boost_s2_r <= boost_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  assign wr_pwr = i_reg_wr && (i_reg_addr == pibc_pkg::ADDR_POWER_MODE);
  assign wr_ien = i_reg_wr && (i_reg_addr == pibc_pkg::ADDR_IRQ_ENABLE);
  assign wr_bp = i_reg_wr && (i_reg_addr == pibc_pkg::ADDR_BREAKPOINT);

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      wake_en_r <= pibc_pkg::PWR_RESET;
    end else if (wr_pwr) begin
      wake_en_r <= i_reg_wdata & pibc_pkg::PWR_WAKE_MASK;
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      ien_r <= pibc_pkg::IEN_RESET;
    end else if (wr_ien) begin
      ien_r <= (i_reg_wdata & pibc_pkg::IEN_WRITE_MASK) | pibc_pkg::IEN_RESERVED_ONE;
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      bp_addr_r <= pibc_pkg::BP_RESET;
    end else if (wr_bp) begin
      bp_addr_r <= i_reg_wdata;
    end
  end

  // boost status is read from the pad, never stored
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      rdata_r <= pibc_pkg::ZERO16;
    end else if (i_reg_rd) begin
      unique case (i_reg_addr)
        pibc_pkg::ADDR_POWER_MODE: begin
          rdata_r <= wake_en_r;
          rdata_r[pibc_pkg::BIT_BOOST_LOW] <= boost_s2_r;
          rdata_r[pibc_pkg::BIT_SLEEP] <= (state_r == pibc_pkg::ST_SLEEP);
          rdata_r[pibc_pkg::BIT_HALT] <= (state_r == pibc_pkg::ST_HALT);
        end
        pibc_pkg::ADDR_IRQ_ENABLE: begin
          rdata_r <= ien_r;
        end
        pibc_pkg::ADDR_BREAKPOINT: begin
          rdata_r <= bp_addr_r;
        end
        default: begin
          rdata_r <= pibc_pkg::ZERO16;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // interrupt gate
  // ----------------------------------------------------------------
  assign gif.event_pulse = i_irq_event;
  assign gif.ack = i_irq_ack;
  assign gif.enable = ien_r;

  pibc_irq_gate u_gate (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .gif(gif.gate)
  );

  // ----------------------------------------------------------------
  // breakpoint
  // ----------------------------------------------------------------
  assign bp_match = i_pc_valid && (i_pc == bp_addr_r);

  // a match wins over a clearing write
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      bp_irq_r <= 1'b0;
    end else if (bp_match) begin
      bp_irq_r <= 1'b1;
    end else if (wr_bp && (i_reg_wdata == pibc_pkg::ZERO16)) begin
      bp_irq_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // power mode sequencer
  // ----------------------------------------------------------------
  // transitions on enabled wake lines only
  assign wake_hit = (wake_s2_r ^ wake_s3_r) & wake_en_r;
  assign resume_done = (resume_cnt_r >= 17'(P_RESUME_CYCLES - 1));

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      pibc_pkg::ST_RUN: begin
        // only a one starts a mode; sleep has priority
        if (wr_pwr && i_reg_wdata[pibc_pkg::BIT_SLEEP]) begin
          state_nxt = pibc_pkg::ST_SLEEP;
        end else if (wr_pwr && i_reg_wdata[pibc_pkg::BIT_HALT]) begin
          state_nxt = pibc_pkg::ST_HALT;
        end
      end
      pibc_pkg::ST_HALT: begin
        // any enabled interrupt releases the cpu
        if (gif.request != pibc_pkg::ZERO16) begin
          state_nxt = pibc_pkg::ST_RUN;
        end
      end
      pibc_pkg::ST_SLEEP: begin
        if (wake_hit != pibc_pkg::ZERO16) begin
          state_nxt = pibc_pkg::ST_RESUME;
        end
      end
      pibc_pkg::ST_RESUME: begin
        if (resume_done) begin
          state_nxt = pibc_pkg::ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      state_r <= pibc_pkg::ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // settle time for oscillator and rails after wake
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      resume_cnt_r <= 17'h00000;
    end else if ((state_r == pibc_pkg::ST_RESUME) && !resume_done) begin
      // clears to zero at the end count so it never passes the resume bound
      resume_cnt_r <= resume_cnt_r + 17'h00001;
    end else begin
      resume_cnt_r <= 17'h00000;
    end
  end

  // clock stop also freezes counters and pwm levels
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      clock_stop_r <= 1'b0;
      power_down_r <= 1'b0;
    end else begin
      clock_stop_r <= (state_nxt == pibc_pkg::ST_SLEEP);
      power_down_r <= (state_nxt == pibc_pkg::ST_SLEEP);
    end
  end

  // halt stops the cpu alone; peripherals keep their clock
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      cpu_stop_r <= 1'b0;
    end else begin
      cpu_stop_r <= (state_nxt != pibc_pkg::ST_RUN);
    end
  end

  assign o_reg_rdata = rdata_r;
  assign o_irq_req = gif.request;
  assign o_breakpoint_irq = bp_irq_r;
  assign o_cpu_stop = cpu_stop_r;
  assign o_clock_stop = clock_stop_r;
  assign o_analog_power_down = power_down_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_sleep_write;
    state_r == pibc_pkg::ST_RUN && wr_pwr && i_reg_wdata[pibc_pkg::BIT_SLEEP];
  endsequence

  sequence s_halt_write;
    state_r == pibc_pkg::ST_RUN && wr_pwr && i_reg_wdata[pibc_pkg::BIT_HALT]
      && !i_reg_wdata[pibc_pkg::BIT_SLEEP];
  endsequence

  sequence s_powered_down;
    o_clock_stop && o_analog_power_down && o_cpu_stop;
  endsequence

  a_sleep_entry: assert property (@(posedge i_clock) disable iff (i_reset)
    s_sleep_write |=> s_powered_down)
    else $error("sleep write did not stop clock");

  a_halt_entry: assert property (@(posedge i_clock) disable iff (i_reset)
    s_halt_write |=> o_cpu_stop && !o_clock_stop && !o_analog_power_down)
    else $error("halt write did not stop cpu alone");

  a_halt_exit: assert property (@(posedge i_clock) disable iff (i_reset)
    state_r == pibc_pkg::ST_HALT && gif.request != pibc_pkg::ZERO16 |=> !o_cpu_stop)
    else $error("enabled interrupt did not end halt");

  a_wake_gated: assert property (@(posedge i_clock) disable iff (i_reset)
    state_r == pibc_pkg::ST_SLEEP && wake_hit == pibc_pkg::ZERO16 |=> o_clock_stop)
    else $error("sleep left without enabled wake");

  a_resume_bound: assert property (@(posedge i_clock) disable iff (i_reset)
    resume_cnt_r < 17'(P_RESUME_CYCLES))
    else $error("resume exceeded its bound");

  a_zero_write_inert: assert property (@(posedge i_clock) disable iff (i_reset)
    state_r == pibc_pkg::ST_RUN && wr_pwr && !i_reg_wdata[pibc_pkg::BIT_SLEEP]
      && !i_reg_wdata[pibc_pkg::BIT_HALT] |=> !o_cpu_stop)
    else $error("zero write changed power mode");

  a_req_has_pending: assert property (@(posedge i_clock) disable iff (i_reset)
    (gif.request & ~gif.pending) == pibc_pkg::ZERO16)
    else $error("request raised without pending flag");

  a_bp_raise: assert property (@(posedge i_clock) disable iff (i_reset)
    bp_match |=> o_breakpoint_irq)
    else $error("breakpoint match missed");

  a_bp_clear: assert property (@(posedge i_clock) disable iff (i_reset)
    wr_bp && i_reg_wdata == pibc_pkg::ZERO16 && !bp_match |=> !o_breakpoint_irq)
    else $error("breakpoint not cleared by zero write");

  a_boost_read: assert property (@(posedge i_clock) disable iff (i_reset)
    i_reg_rd && i_reg_addr == pibc_pkg::ADDR_POWER_MODE && !wr_pwr
      |=> o_reg_rdata[pibc_pkg::BIT_BOOST_LOW] == $past(boost_s2_r))
    else $error("boost status misreported");

endmodule

// file: rtl/pibc_pkg.sv
/*
  constants for the power, interrupt-enable and breakpoint controller.
  assumes a 16-bit cpu register port clocked by i_clock at 125 MHz.
*/
package pibc_pkg;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_POWER_MODE = 16'hC00A;
  localparam logic [15:0] ADDR_IRQ_ENABLE = 16'hC00E;
  localparam logic [15:0] ADDR_BREAKPOINT = 16'hC014;

  // ----------------------------------------------------------------
  // power mode control fields
  // ----------------------------------------------------------------
  localparam int BIT_HALT = 0;
  localparam int BIT_SLEEP = 1;
  localparam int BIT_BOOST_LOW = 2;
  // writable wake enables: 15..11, 9, 8, 7, 4
  localparam logic [15:0] PWR_WAKE_MASK = 16'hFB90;
  localparam logic [15:0] PWR_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // interrupt enable fields
  // ----------------------------------------------------------------
  localparam int IEN_OTG = 12;
  localparam int IEN_SPI = 11;
  localparam int IEN_ENGINE2 = 9;
  localparam int IEN_ENGINE1 = 8;
  localparam int IEN_FAST_SERIAL = 7;
  localparam int IEN_MBX_IN = 6;
  localparam int IEN_MBX_OUT = 5;
  localparam int IEN_UART = 3;
  localparam int IEN_GPIO = 2;
  localparam int IEN_TIMER1 = 1;
  localparam int IEN_TIMER0 = 0;
  localparam logic [15:0] IEN_WRITE_MASK = 16'h1BEF;
  // reserved bit 4 reads back as one
  localparam logic [15:0] IEN_RESERVED_ONE = 16'h0010;
  localparam logic [15:0] IEN_RESET = 16'h0010;
  // groups whose pending flags are discarded when disabled
  localparam logic [15:0] IEN_DISCARD_MASK = 16'h0007;

  localparam logic [15:0] BP_RESET = 16'h0000;
  localparam logic [15:0] ZERO16 = 16'h0000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int RESUME_MAX_NS = 500000;
  // longest time, so rounded down
  localparam int RESUME_CYCLES = RESUME_MAX_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_HALT,
    ST_SLEEP,
    ST_RESUME
  } pibc_mode_e;

endpackage

// file: rtl/pibc_gate_if.sv
/*
  carrier between the controller and its per-source interrupt gate.
  assumes both ends share i_clock.
*/
`timescale 1ns/1ps
interface pibc_gate_if;
  logic [15:0] event_pulse;
  logic [15:0] ack;
  logic [15:0] enable;
  logic [15:0] pending;
  logic [15:0] request;

  modport ctrl (
    output event_pulse,
    output ack,
    output enable,
    input pending,
    input request
  );

  modport gate (
    input event_pulse,
    input ack,
    input enable,
    output pending,
    output request
  );
endinterface

// file: rtl/pibc_irq_gate.sv
/*
  per-source pending flags gated by the interrupt enable bits.
  assumes event and ack pulses are synchronous to i_clock.
*/
`timescale 1ns/1ps
module pibc_irq_gate (
  input wire logic i_clock,
  input wire logic i_reset,
  pibc_gate_if.gate gif
);

  logic [15:0] pend_r;
  logic [15:0] req_r;
  logic [15:0] pend_nxt;

  // ----------------------------------------------------------------
  // pending flags, one per source group
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_src
      logic clr;
      assign clr = gif.ack[g] | (pibc_pkg::IEN_DISCARD_MASK[g] & ~gif.enable[g]);
      // an event in the clearing cycle still wins
      assign pend_nxt[g] = gif.event_pulse[g] | (pend_r[g] & ~clr);
    end
  endgenerate

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      pend_r <= pibc_pkg::ZERO16;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      req_r <= pibc_pkg::ZERO16;
    end else begin
      req_r <= pend_nxt & gif.enable & pibc_pkg::IEN_WRITE_MASK;
    end
  end

  assign gif.pending = pend_r;
  assign gif.request = req_r;

  sequence s_timer0_off_quiet;
    !gif.enable[0] && !gif.event_pulse[0];
  endsequence

  a_gate_needs_enable: assert property (@(posedge i_clock) disable iff (i_reset)
    (gif.request != pibc_pkg::ZERO16) |-> $past(gif.enable) != pibc_pkg::ZERO16)
    else $error("request raised with no enable set");

  a_timer0_discard: assert property (@(posedge i_clock) disable iff (i_reset)
    s_timer0_off_quiet |=> !pend_r[0] && !req_r[0])
    else $error("timer0 pending kept while disabled");

endmodule

// file: sim/test_pibc_top.sv
/*
  self-checking bench for the power mode, interrupt enable and breakpoint controller.
  assumes the design files under rtl/ are compiled first; inputs change on falling edges.
*/
`timescale 1ns/1ps
module test_pibc_top;
  // short resume count keeps the sleep exit test brief
  localparam int RESUME = 8;
  localparam int TIMEOUT = 5000;
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic [15:0] i_reg_addr = 16'h0000;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [15:0] i_reg_wdata = 16'h0000;
  logic [15:0] o_reg_rdata;
  logic i_boost_low = 1'b0;
  logic [15:0] i_wake_line = 16'h0000;
  logic [15:0] i_irq_event = 16'h0000;
  logic [15:0] i_irq_ack = 16'h0000;
  logic [15:0] i_pc = 16'h0000;
  logic i_pc_valid = 1'b0;
  logic [15:0] o_irq_req;
  logic o_breakpoint_irq;
  logic o_cpu_stop;
  logic o_clock_stop;
  logic o_analog_power_down;
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;

  pibc_top #(.P_RESUME_CYCLES(RESUME)) DUT (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd),
    .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata),
    .i_boost_low(i_boost_low),
    .i_wake_line(i_wake_line),
    .i_irq_event(i_irq_event),
    .i_irq_ack(i_irq_ack),
    .i_pc(i_pc),
    .i_pc_valid(i_pc_valid),
    .o_irq_req(o_irq_req),
    .o_breakpoint_irq(o_breakpoint_irq),
    .o_cpu_stop(o_cpu_stop),
    .o_clock_stop(o_clock_stop),
    .o_analog_power_down(o_analog_power_down)
  );

  always #4 i_clock = ~i_clock;

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge i_clock) begin
    cycles = cycles + 1;
    if (cycles == TIMEOUT) begin
      fails = fails + 1;
      $display("Error timeout after %0d cycles", cycles);
      complete_run();
    end
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge i_clock);
  endtask

  task automatic reg_write(input logic [15:0] addr, input logic [15:0] data);
    @(negedge i_clock);
    i_reg_addr = addr;
    i_reg_wdata = data;
    i_reg_wr = 1'b1;
    @(negedge i_clock);
    i_reg_wr = 1'b0;
  endtask

  task automatic read_check(input string name, input logic [15:0] addr, input logic [15:0] exp);
    @(negedge i_clock);
    i_reg_addr = addr;
    i_reg_rd = 1'b1;
    @(negedge i_clock);
    i_reg_rd = 1'b0;
    check(name, o_reg_rdata, exp);
  endtask

  // one-cycle pulse on the event lines, or on the ack lines when is_ack is set
  task automatic pulse(input bit is_ack, input logic [15:0] m);
    @(negedge i_clock);
    if (is_ack) i_irq_ack = m;
    else i_irq_event = m;
    @(negedge i_clock);
    i_irq_ack = 16'h0000;
    i_irq_event = 16'h0000;
    tick(1);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int bits[11];
    logic [15:0] m;
    int n;
    bits = '{12, 11, 9, 8, 7, 6, 5, 3, 2, 1, 0};
    repeat (4) @(posedge i_clock);
    @(negedge i_clock);
    i_reset = 1'b0;
    tick(4);
    read_check("enable reset", pibc_pkg::ADDR_IRQ_ENABLE, 16'h0010);
    read_check("power reset", pibc_pkg::ADDR_POWER_MODE, 16'h0000);
    read_check("breakpoint reset", pibc_pkg::ADDR_BREAKPOINT, 16'h0000);
    reg_write(16'hC010, 16'hFFFF);
    read_check("unmapped read", 16'hC010, 16'h0000);
    read_check("enable untouched", pibc_pkg::ADDR_IRQ_ENABLE, 16'h0010);
    $display("test reset done");

    // boost status is read-only and follows the pad
    i_boost_low = 1'b1;
    tick(4);
    read_check("boost low", pibc_pkg::ADDR_POWER_MODE, 16'h0004);
    reg_write(pibc_pkg::ADDR_POWER_MODE, 16'h0000);
    check("zero write", {15'h0000, o_cpu_stop | o_clock_stop}, 16'h0000);
    i_boost_low = 1'b0;
    tick(4);
    read_check("boost ok", pibc_pkg::ADDR_POWER_MODE, 16'h0000);
    // wake enables are stored but do nothing outside sleep
    reg_write(pibc_pkg::ADDR_POWER_MODE, 16'hFB90);
    read_check("wake enables", pibc_pkg::ADDR_POWER_MODE, 16'hFB90);
    i_wake_line = 16'hFB90;
    tick(6);
    check("no wake in run", {15'h0000, o_cpu_stop | o_clock_stop}, 16'h0000);
    $display("test power register done");

    // reserved enable bits mask off and never request
    reg_write(pibc_pkg::ADDR_IRQ_ENABLE, 16'h1BEF);
    read_check("enable mask", pibc_pkg::ADDR_IRQ_ENABLE, 16'h1BFF);
    pulse(1'b0, 16'hE410);
    check("reserved request", o_irq_req, 16'h0000);
    $display("test reserved enables done");

    // each group: gate, pend while disabled, discard on disable for timers and gpio
    foreach (bits[i]) begin
      m = 16'h0001 << bits[i];
      reg_write(pibc_pkg::ADDR_IRQ_ENABLE, m);
      pulse(1'b0, m);
      check("request enabled", o_irq_req, m);
      pulse(1'b1, m);
      check("request acked", o_irq_req, 16'h0000);
      pulse(1'b0, m);
      reg_write(pibc_pkg::ADDR_IRQ_ENABLE, 16'h0000);
      tick(1);
      check("request disabled", o_irq_req, 16'h0000);
      reg_write(pibc_pkg::ADDR_IRQ_ENABLE, m);
      tick(1);
      check("request reenabled", o_irq_req, (bits[i] < 3) ? 16'h0000 : m);
      pulse(1'b1, m);
      reg_write(pibc_pkg::ADDR_IRQ_ENABLE, 16'h0000);
      pulse(1'b0, m);
      check("gated event", o_irq_req, 16'h0000);
      pulse(1'b1, m);
    end
    $display("test interrupt gating done");

    // halt stops only the cpu until an enabled request
    reg_write(pibc_pkg::ADDR_IRQ_ENABLE, 16'h0001);
    reg_write(pibc_pkg::ADDR_POWER_MODE, 16'h0001);
    tick(1);
    check("halt stop", {13'h0000, o_cpu_stop, o_clock_stop, o_analog_power_down}, 16'h0004);
    tick(5);
    check("halt holds", {15'h0000, o_cpu_stop}, 16'h0001);
    pulse(1'b0, 16'h0001);
    n = 0;
    while (o_cpu_stop !== 1'b0 && n < 4) begin
      tick(1);
      n++;
    end
    check("halt exit", {15'h0000, o_cpu_stop}, 16'h0000);
    check("halt request", o_irq_req, 16'h0001);
    pulse(1'b1, 16'h0001);
    $display("test halt done");

    // sleep stops the clock until an enabled wake line moves
    i_wake_line = 16'h0000;
    tick(6);
    reg_write(pibc_pkg::ADDR_POWER_MODE, 16'h0012);
    tick(1);
    check("sleep stop", {13'h0000, o_cpu_stop, o_clock_stop, o_analog_power_down}, 16'h0007);
    i_wake_line = 16'h0080;
    tick(8);
    check("unselected wake", {15'h0000, o_clock_stop}, 16'h0001);
    i_wake_line = 16'h0090;
    n = 0;
    while (o_clock_stop !== 1'b0 && n < 8) begin
      tick(1);
      n++;
    end
    check("wake clock", {14'h0000, o_clock_stop, o_analog_power_down}, 16'h0000);
    check("resume stop", {15'h0000, o_cpu_stop}, 16'h0001);
    n = 0;
    while (o_cpu_stop !== 1'b0 && n < RESUME + 4) begin
      tick(1);
      n++;
    end
    check("resume end", {15'h0000, o_cpu_stop}, 16'h0000);
    check("resume bound", {15'h0000, n <= RESUME + 1}, 16'h0001);
    // sleep and halt together: sleep takes priority
    reg_write(pibc_pkg::ADDR_POWER_MODE, 16'h0013);
    tick(1);
    check("sleep priority", {13'h0000, o_cpu_stop, o_clock_stop, o_analog_power_down}, 16'h0007);
    i_wake_line = 16'h0080;
    tick(RESUME + 6);
    check("priority wake", {15'h0000, o_cpu_stop | o_clock_stop}, 16'h0000);
    $display("test sleep done");

    // breakpoint raises on a qualified match and drops on a zero write
    reg_write(pibc_pkg::ADDR_BREAKPOINT, 16'h1234);
    read_check("breakpoint value", pibc_pkg::ADDR_BREAKPOINT, 16'h1234);
    i_pc = 16'h1234;
    tick(3);
    check("unqualified pc", {15'h0000, o_breakpoint_irq}, 16'h0000);
    i_pc_valid = 1'b1;
    tick(1);
    i_pc_valid = 1'b0;
    i_pc = 16'h0400;
    tick(1);
    check("breakpoint hit", {15'h0000, o_breakpoint_irq}, 16'h0001);
    tick(4);
    check("breakpoint sticky", {15'h0000, o_breakpoint_irq}, 16'h0001);
    reg_write(pibc_pkg::ADDR_BREAKPOINT, 16'h0000);
    tick(1);
    check("breakpoint cleared", {15'h0000, o_breakpoint_irq}, 16'h0000);
    $display("test breakpoint done");
    complete_run();
  end
endmodule
